/* File: swp_pkg.sv */
// Package of register map, field layout, enumerations and timing for the sweep sequencer
package swp_pkg;
	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CMD = 8'h04;
	localparam logic [7:0] REG_TICK = 8'h08;
	localparam logic [7:0] REG_START = 8'h0C;
	localparam logic [7:0] REG_STOP = 8'h10;
	localparam logic [7:0] REG_CENTER = 8'h14;
	localparam logic [7:0] REG_SPAN = 8'h18;
	localparam logic [7:0] REG_MARKER = 8'h1C;
	localparam logic [7:0] REG_MKPOS = 8'h20;
	localparam logic [7:0] REG_STATUS = 8'h24;
	localparam logic [7:0] REG_LOW = 8'h28;
	localparam logic [7:0] REG_HIGH = 8'h2C;
	// ==========================================================
	// Control field positions
	localparam int CTRL_SYNC_LSB = 0;
	localparam int CTRL_MODE_LSB = 2;
	localparam int CTRL_SHUTTLE = 4;
	localparam int CTRL_LOG = 5;
	localparam int CTRL_TYPE_LSB = 6;
	localparam int CTRL_WAVE_LSB = 8;
	localparam int CTRL_EXT_EN = 11;
	localparam int CTRL_IDLE_LVL = 12;
	localparam int CTRL_HALT_HALF = 13;
	localparam int CTRL_CENTER = 14;
	localparam int CTRL_W = 15;
	// ==========================================================
	// Command bits, write one to act
	localparam int CMD_START = 0;
	localparam int CMD_STOP = 1;
	localparam int CMD_HOLD = 2;
	localparam int CMD_RESUME = 3;
	localparam int CMD_CTR2MKR = 4;
	localparam int CMD_MKR2CTR = 5;
	localparam int CMD_TRIG = 6;
	// ==========================================================
	// Reset values and sweep position limits
	localparam logic [CTRL_W-1:0] CTRL_RST = 15'h0000;
	localparam logic [31:0] TICK_RST = 32'h00000001;
	localparam int POS_W = 15;
	localparam logic [POS_W-1:0] POS_MAX = 15'h7FFF;
	localparam logic [POS_W-1:0] MARK_MIN = 15'h0010;
	localparam logic [POS_W-1:0] MARK_MAX = 15'h7FF0;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_PS = 50000;
	localparam int MIN_STEP_PS = 8330;
	localparam int MIN_STEP_CYC_I = (MIN_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [31:0] MIN_STEP_CYC = (MIN_STEP_CYC_I < 1) ? 32'h1 : 32'(MIN_STEP_CYC_I);
	// ==========================================================
	// Enumerations
	typedef enum logic [1:0] {
		SYNC_REF = 2'b00, SYNC_SWEEP = 2'b01, SYNC_MARKER = 2'b10, SYNC_XDRIVE = 2'b11
	} swp_sync_t;
	typedef enum logic [1:0] {
		MODE_CONT = 2'b00, MODE_SINGLE = 2'b01, MODE_GATED = 2'b10
	} swp_mode_t;
	typedef enum logic [1:0] {
		TYPE_FREQ = 2'b00, TYPE_PHASE = 2'b01, TYPE_AMPL = 2'b10
	} swp_type_t;
	typedef enum logic [2:0] {
		WAVE_SINE = 3'b000, WAVE_SQUARE = 3'b001, WAVE_TRI = 3'b010, WAVE_RAMP = 3'b011,
		WAVE_PULSE = 3'b100, WAVE_NOISE = 3'b101, WAVE_DC = 3'b110, WAVE_ARB = 3'b111
	} swp_wave_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_HOLD = 2'b10, ST_DONE = 2'b11
	} swp_state_t;
endpackage

/* File: swp_pin_edge.sv */
// Two-flop synchroniser with edge detection for external logic pins
`timescale 1ns/1ps
`default_nettype none
module swp_pin_edge #(
	parameter int W = 4
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] fall,
	output logic [W-1:0] rise
);
	logic [W-1:0] meta;
	logic [W-1:0] sync;
	logic [W-1:0] prev;

	// ==========================================================
	// Synchroniser, idle high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta <= '1;
			sync <= '1;
			prev <= '1;
		end else begin
			meta <= pin;
			sync <= meta;
			prev <= sync;
		end
	end

	assign fall = prev & ~sync;
	assign rise = ~prev & sync;
endmodule
`default_nettype wire

/* File: swp_seq.sv */
// Sweep sequencer with sync output selection and AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module swp_seq
	import swp_pkg::*;
#(
	parameter int VAL_W = 32
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic ext_start_n,
	input wire logic ext_stop_n,
	input wire logic ext_hold_n,
	input wire logic trig_pin,
	input wire logic ref_phase,
	output logic sync_out,
	output logic [11:0] xdrive_code,
	output logic [swp_pkg::POS_W-1:0] sweep_pos,
	output logic sweep_begin,
	output logic [VAL_W-1:0] sweep_lo,
	output logic [VAL_W-1:0] sweep_hi,
	output logic idle_level_en,
	output logic halt_half_cycle
);
	import swp_pkg::*;

	function automatic logic [POS_W-1:0] clamp_mark(input logic [POS_W-1:0] p);
		if (p < MARK_MIN) begin
			return MARK_MIN;
		end else if (p > MARK_MAX) begin
			return MARK_MAX;
		end
		return p;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Registers
	logic [CTRL_W-1:0] ctrl;
	logic [31:0] tick_len;
	logic [31:0] start_val;
	logic [31:0] stop_val;
	logic [31:0] center;
	logic [31:0] span;
	logic [31:0] marker;
	logic [POS_W-1:0] mkpos;
	logic [7:0] aw_addr;
	logic aw_full;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic w_full;
	logic wr_go;
	logic [6:0] cmd;

	swp_sync_t sync_sel;
	swp_mode_t mode;
	swp_type_t stype;
	swp_wave_t wave;
	assign sync_sel = swp_sync_t'(ctrl[CTRL_SYNC_LSB +: 2]);
	assign mode = swp_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
	assign stype = swp_type_t'(ctrl[CTRL_TYPE_LSB +: 2]);
	assign wave = swp_wave_t'(ctrl[CTRL_WAVE_LSB +: 3]);

	// ==========================================================
	// AXI4-Lite write channel
	assign s_axi_awready = !aw_full && !s_axi_bvalid;
	assign s_axi_wready = !w_full && !s_axi_bvalid;
	assign s_axi_bresp = 2'h0;
	assign wr_go = aw_full && w_full && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full <= 1'b0;
			aw_addr <= 8'h00;
			w_full <= 1'b0;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full <= 1'b0;
				w_full <= 1'b0;
				s_axi_bvalid <= 1'b1;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= CTRL_RST;
			tick_len <= TICK_RST;
			start_val <= 32'h00000000;
			stop_val <= 32'h00000000;
			center <= 32'h00000000;
			span <= 32'h00000000;
			marker <= 32'h00000000;
			mkpos <= 15'h0000;
			cmd <= 7'h00;
		end else begin
			cmd <= 7'h00;
			if (wr_go) begin
				unique case ({aw_addr[7:2], 2'b00})
					REG_CTRL: ctrl <= CTRL_W'(merge(32'(ctrl), w_data, w_strb));
					REG_CMD: cmd <= w_strb[0] ? w_data[6:0] : 7'h00;
					REG_TICK: tick_len <= merge(tick_len, w_data, w_strb);
					REG_START: start_val <= merge(start_val, w_data, w_strb);
					REG_STOP: stop_val <= merge(stop_val, w_data, w_strb);
					REG_CENTER: center <= merge(center, w_data, w_strb);
					REG_SPAN: span <= merge(span, w_data, w_strb);
					REG_MARKER: marker <= merge(marker, w_data, w_strb);
					REG_MKPOS: mkpos <= POS_W'(merge(32'(mkpos), w_data, w_strb));
					default: ;
				endcase
			end
			if (cmd[CMD_CTR2MKR]) begin
				marker <= center;
			end
			if (cmd[CMD_MKR2CTR]) begin
				center <= marker;
			end
		end
	end

	// ==========================================================
	// Pin edges and command decode
	logic [3:0] pin_fall;
	logic [3:0] pin_rise;
	logic conflict;
	logic ext_ok;
	logic ext_start;
	logic stop_any;
	logic hold_any;
	logic resume_any;
	logic trig_any;
	logic one_shot;
	logic restart;

	swp_pin_edge #(.W(4)) u_pins (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin({~trig_pin, ext_hold_n, ext_stop_n, ext_start_n}),
		.fall(pin_fall),
		.rise(pin_rise)
	);

	always_comb begin
		conflict = 1'b0;
		unique case (stype)
			TYPE_FREQ: conflict = (wave == WAVE_NOISE) || (wave == WAVE_PULSE) ||
				(wave == WAVE_DC);
			TYPE_PHASE: conflict = (wave == WAVE_NOISE) || (wave == WAVE_DC);
			TYPE_AMPL: conflict = (wave == WAVE_DC);
			default: conflict = 1'b1;
		endcase
	end

	assign ext_ok = ctrl[CTRL_EXT_EN] && !conflict;
	assign ext_start = ext_ok && pin_fall[0];
	assign stop_any = cmd[CMD_STOP] || (ext_ok && pin_fall[1]);
	assign hold_any = cmd[CMD_HOLD] || (ext_ok && pin_fall[2]);
	assign resume_any = cmd[CMD_RESUME] || (ext_ok && pin_rise[2]);
	assign one_shot = (mode == MODE_SINGLE) || (mode == MODE_GATED);
	assign trig_any = ((pin_fall[3] || cmd[CMD_TRIG]) && !conflict) || ext_start;
	assign restart = ext_start || (cmd[CMD_START] && !conflict) ||
		(one_shot && trig_any);

	// ==========================================================
	// Sweep state machine
	swp_state_t state;
	logic [31:0] tcnt;
	logic tick;
	logic dir;
	logic at_end;
	logic [31:0] tick_eff;

	assign tick_eff = (tick_len < MIN_STEP_CYC) ? MIN_STEP_CYC : tick_len;
	assign tick = (state == ST_RUN) && (tcnt >= tick_eff - 32'h1);
	assign at_end = dir ? (sweep_pos == 15'h0000) :
		(sweep_pos == POS_MAX && !ctrl[CTRL_SHUTTLE]);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			sweep_pos <= 15'h0000;
			dir <= 1'b0;
			tcnt <= 32'h00000000;
			sweep_begin <= 1'b0;
		end else begin
			sweep_begin <= 1'b0;
			if (conflict || (stop_any && state != ST_IDLE)) begin
				state <= ST_IDLE;
				sweep_pos <= 15'h0000;
				dir <= 1'b0;
				tcnt <= 32'h00000000;
			end else if (restart) begin
				state <= ST_RUN;
				sweep_pos <= 15'h0000;
				dir <= 1'b0;
				tcnt <= 32'h00000000;
				sweep_begin <= 1'b1;
			end else if (hold_any && state == ST_RUN) begin
				state <= ST_HOLD;
			end else if (resume_any && state == ST_HOLD) begin
				state <= ST_RUN;
			end else if (state == ST_RUN) begin
				tcnt <= tick ? 32'h00000000 : tcnt + 32'h1;
				if (tick && at_end) begin
					sweep_pos <= 15'h0000;
					dir <= 1'b0;
					if (!one_shot) begin
						sweep_begin <= 1'b1;
					end else if (ctrl[CTRL_SHUTTLE]) begin
						state <= ST_DONE;
					end else begin
						state <= ST_IDLE;
					end
				end else if (tick && !dir && sweep_pos == POS_MAX) begin
					dir <= 1'b1;
					sweep_pos <= sweep_pos - 15'h1;
				end else if (tick) begin
					sweep_pos <= dir ? sweep_pos - 15'h1 : sweep_pos + 15'h1;
				end
			end
		end
	end

	// ==========================================================
	// Effective limits and gated-only options
	logic signed [31:0] half_span;
	logic signed [31:0] eff_start;
	logic signed [31:0] eff_stop;
	logic rev;
	logic log_eff;

	assign log_eff = ctrl[CTRL_LOG] && (stype == TYPE_FREQ);
	assign half_span = $signed(span) >>> 1;
	assign eff_start = ctrl[CTRL_CENTER] ? $signed(center) - half_span : $signed(start_val);
	assign eff_stop = ctrl[CTRL_CENTER] ? $signed(center) + half_span : $signed(stop_val);
	assign rev = eff_stop < eff_start;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sweep_lo <= '0;
			sweep_hi <= '0;
			idle_level_en <= 1'b0;
			halt_half_cycle <= 1'b0;
		end else begin
			sweep_lo <= VAL_W'(eff_start);
			sweep_hi <= VAL_W'(eff_stop);
			idle_level_en <= (mode == MODE_GATED) && ctrl[CTRL_IDLE_LVL];
			halt_half_cycle <= (mode == MODE_GATED) && ctrl[CTRL_HALT_HALF];
		end
	end

	// ==========================================================
	// Sync output generation
	logic sweep_lvl;
	logic mk_lvl;
	logic [POS_W-1:0] mk_edge;

	assign mk_edge = clamp_mark(mkpos);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sweep_lvl <= 1'b1;
			mk_lvl <= 1'b1;
			sync_out <= 1'b0;
			xdrive_code <= 12'h000;
		end else begin
			if (sweep_begin) begin
				sweep_lvl <= 1'b0;
				mk_lvl <= 1'b0;
			end else if (state == ST_IDLE) begin
				sweep_lvl <= 1'b1;
				mk_lvl <= 1'b1;
			end else begin
				if (dir) begin
					sweep_lvl <= 1'b1;
				end
				if (!dir && sweep_pos >= mk_edge) begin
					mk_lvl <= 1'b1;
				end
			end
			unique case (sync_sel)
				SYNC_REF: sync_out <= ref_phase;
				SYNC_SWEEP: sync_out <= sweep_lvl;
				SYNC_MARKER: sync_out <= mk_lvl;
				SYNC_XDRIVE: sync_out <= 1'b0;
			endcase
			xdrive_code <= rev ? ~sweep_pos[POS_W-1 -: 12] : sweep_pos[POS_W-1 -: 12];
		end
	end

	// ==========================================================
	// AXI4-Lite read channel
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		unique case ({s_axi_araddr[7:2], 2'b00})
			REG_CTRL: rd_mux = 32'(ctrl);
			REG_TICK: rd_mux = tick_len;
			REG_START: rd_mux = start_val;
			REG_STOP: rd_mux = stop_val;
			REG_CENTER: rd_mux = center;
			REG_SPAN: rd_mux = span;
			REG_MARKER: rd_mux = marker;
			REG_MKPOS: rd_mux = 32'(mkpos);
			REG_STATUS: rd_mux = {11'h000, log_eff, sweep_pos, sync_out, dir, conflict, state};
			REG_LOW: rd_mux = 32'(eff_start);
			REG_HIGH: rd_mux = 32'(eff_stop);
			default: rd_mux = 32'h00000000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign s_axi_rresp = 2'h0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_stop_to_idle: assert property (stop_any && state != ST_IDLE |=>
		state == ST_IDLE && sweep_pos == 15'h0000) else $error("stop not honoured");
	a_ext_restart: assert property (ext_start && !stop_any |=>
		state == ST_RUN && sweep_pos == 15'h0000 && sweep_begin)
		else $error("ext start missed");
	a_trig_restart: assert property (one_shot && trig_any && !stop_any && !conflict |=>
		state == ST_RUN && sweep_pos == 15'h0000) else $error("trigger missed");
	a_hold_freeze: assert property (state == ST_HOLD ##1 state == ST_HOLD |->
		$stable(sweep_pos)) else $error("pos moved in hold");
	a_sweep_falls: assert property (sweep_begin && sync_sel == SYNC_SWEEP ##1
		sync_sel == SYNC_SWEEP |=> !sync_out) else $error("sweep sync not low");
	a_marker_return: assert property ((state == ST_RUN && dir)[*2] |->
		$stable(mk_lvl)) else $error("marker moved on return");
	a_marker_clamp: assert property ($rose(mk_lvl) && $past(state) == ST_RUN |->
		$past(sweep_pos) >= MARK_MIN) else $error("marker below clamp");
	a_freq_refuse: assert property (stype == TYPE_FREQ && (wave == WAVE_PULSE ||
		wave == WAVE_NOISE || wave == WAVE_DC) |=> state == ST_IDLE)
		else $error("bad freq sweep ran");
	a_phase_refuse: assert property (stype == TYPE_PHASE && (wave == WAVE_NOISE ||
		wave == WAVE_DC) |=> state == ST_IDLE) else $error("bad phase sweep ran");
	a_xdrive_rev: assert property (rev && state == ST_RUN && sweep_pos == 15'h0000 ##1
		rev |-> xdrive_code == 12'hFFF) else $error("xdrive slope wrong");
	a_gated_only: assert property (mode != MODE_GATED |=> !idle_level_en && !halt_half_cycle)
		else $error("gated option leaked");
	a_oneway_end: assert property (tick && at_end && one_shot && !ctrl[CTRL_SHUTTLE] &&
		!restart && !stop_any && !hold_any && !conflict |=> state == ST_IDLE)
		else $error("one-way end not idle");
endmodule
`default_nettype wire

/* File: swp_pin_src.sv */
// External logic source model for the sweep control and reference phase pins
`timescale 1ns/1ps
`default_nettype none
module swp_pin_src (
	input wire logic aclk,
	output logic ext_start_n,
	output logic ext_stop_n,
	output logic ext_hold_n,
	output logic trig_pin,
	output logic ref_phase
);
	logic [2:0] ph_cnt;
	// ==========================================================
	// Idle levels: logic inputs high, trigger low
	initial begin
		ext_start_n = 1'b1;
		ext_stop_n = 1'b1;
		ext_hold_n = 1'b1;
		trig_pin = 1'b0;
		ref_phase = 1'b0;
		ph_cnt = 3'h0;
	end
	// ==========================================================
	// Reference phase level, eight cycles high and eight low
	always @(posedge aclk) begin
		ph_cnt <= ph_cnt + 3'h1;
		if (ph_cnt == 3'h7) begin
			ref_phase <= ~ref_phase;
		end
	end
	// ==========================================================
	// Pulse of four cycles: 0 start, 1 stop, 2 trigger
	task automatic pulse(input int sel);
		@(posedge aclk);
		ext_start_n <= (sel != 0);
		ext_stop_n <= (sel != 1);
		trig_pin <= (sel == 2);
		repeat (4) @(posedge aclk);
		ext_start_n <= 1'b1;
		ext_stop_n <= 1'b1;
		trig_pin <= 1'b0;
	endtask
	task automatic hold(input logic lvl);
		@(posedge aclk);
		ext_hold_n <= lvl;
	endtask
endmodule
`default_nettype wire

/* File: swp_seq_tb.sv */
// Testbench for the sweep sequencer over AXI4-Lite and the logic pins
`timescale 1ns/1ps
`default_nettype none
module swp_seq_tb;
	import swp_pkg::*;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, sync_out, sweep_begin, idle_level_en, halt_half_cycle;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v, lo, hi;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [11:0] xdrive_code, x0, x1, x2;
	logic [POS_W-1:0] sweep_pos, p;
	wire logic ext_start_n, ext_stop_n, ext_hold_n, trig_pin, ref_phase;
	int err_count, checked;
	swp_seq i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .ext_start_n(ext_start_n), .ext_stop_n(ext_stop_n),
		.ext_hold_n(ext_hold_n), .trig_pin(trig_pin), .ref_phase(ref_phase),
		.sync_out(sync_out), .xdrive_code(xdrive_code), .sweep_pos(sweep_pos),
		.sweep_begin(sweep_begin), .sweep_lo(lo), .sweep_hi(hi),
		.idle_level_en(idle_level_en), .halt_half_cycle(halt_half_cycle));
	swp_pin_src i_src (.aclk(aclk), .ext_start_n(ext_start_n), .ext_stop_n(ext_stop_n),
		.ext_hold_n(ext_hold_n), .trig_pin(trig_pin), .ref_phase(ref_phase));
	// ==========================================================
	// Report and bus tasks
	task automatic print_verdict;
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic da, dw, ah, wh;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		da = 1'b0;
		dw = 1'b0;
		while (!(da && dw)) begin
			@(negedge aclk);
			ah = awvalid && awready;
			wh = wvalid && wready;
			@(posedge aclk);
			if (ah) begin
				awvalid <= 1'b0;
				da = 1'b1;
			end
			if (wh) begin
				wvalid <= 1'b0;
				dw = 1'b1;
			end
		end
		do @(negedge aclk); while (bvalid !== 1'b1);
		chk("bresp", 32'(bresp), 32'h0);
		@(posedge aclk);
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge aclk); while (arready !== 1'b1);
		@(posedge aclk);
		arvalid <= 1'b0;
		do @(negedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		chk("rresp", 32'(rresp), 32'h0);
		@(posedge aclk);
		rready <= 1'b0;
	endtask
	task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		rd(a, v);
		chk(nm, v & m, e);
	endtask
	task automatic pulse_begin(input int sel);
		int n;
		n = 0;
		fork
			i_src.pulse(sel);
			do begin
				@(negedge aclk);
				n++;
			end while (sweep_begin !== 1'b1 && n < 20);
		join
		@(negedge aclk);
		chk("begin", 32'(n < 20), 32'h1);
	endtask
	task automatic wait_pos(input logic [POS_W-1:0] q);
		int n;
		n = 0;
		do begin
			@(negedge aclk);
			n++;
		end while (sweep_pos !== q && n < 40000);
		chk("pos_reached", 32'(sweep_pos), 32'(q));
	endtask
	// ==========================================================
	// Clock, reset, watchdog
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		repeat (90000) @(posedge aclk);
		err_count++;
		print_verdict();
	end
	// ==========================================================
	// Test sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = {16'h0000, 32'h0, 4'hF};
		err_count = 0;
		checked = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rdc("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
		rdc("tick", REG_TICK, 32'hFFFFFFFF, 32'h1);
		rdc("status", REG_STATUS, 32'hFFFFFFEF, 32'h0);
		rdc("unmapped", 8'h30, 32'hFFFFFFFF, 32'h0);
		wr(REG_CTRL, 32'h4000);
		wr(REG_CENTER, 32'h3E8);
		wr(REG_SPAN, 32'hC8);
		rdc("low", REG_LOW, 32'hFFFFFFFF, 32'h384);
		rdc("high", REG_HIGH, 32'hFFFFFFFF, 32'h44C);
		chk("sweep_hi", hi, 32'h44C);
		chk("sweep_lo", lo, 32'h384);
		wr(REG_CMD, 32'h10);
		rdc("ctr2mkr", REG_MARKER, 32'hFFFFFFFF, 32'h3E8);
		wr(REG_MARKER, 32'h55);
		wr(REG_CMD, 32'h20);
		rdc("mkr2ctr", REG_CENTER, 32'hFFFFFFFF, 32'h55);
		wstrb <= 4'h1;
		wr(REG_MARKER, 32'hAABBCCDD);
		wstrb <= 4'hF;
		rdc("strobe", REG_MARKER, 32'hFFFFFFFF, 32'h000000DD);
		for (int t = 0; t < 2; t++) begin
			for (int w = 0; w < 8; w++) begin
				wr(REG_CTRL, {21'h0, 3'(w), 2'(t), 6'h0});
				rdc("conflict", REG_STATUS, 32'h4, (t == 0 && w inside {4, 5, 6}) ||
					(t == 1 && w inside {5, 6}) ? 32'h4 : 32'h0);
			end
		end
		wr(REG_CTRL, 32'h0060);
		rdc("log_phase", REG_STATUS, 32'h100000, 32'h0);
		wr(REG_CTRL, 32'h0020);
		rdc("log_freq", REG_STATUS, 32'h100000, 32'h100000);
		for (int m = 0; m < 3; m++) begin
			wr(REG_CTRL, {18'h0, 2'b11, 8'h0, 2'(m), 2'b00});
			@(negedge aclk);
			chk("idle_lvl", 32'(idle_level_en), 32'(m == 2));
			chk("halt_half", 32'(halt_half_cycle), 32'(m == 2));
		end
		wr(REG_TICK, 32'h10);
		wr(REG_CTRL, 32'h801);
		pulse_begin(0);
		chk("start_pos", 32'(sweep_pos), 32'h0);
		repeat (4) @(negedge aclk);
		chk("sweep_sync", 32'(sync_out), 32'h0);
		i_src.hold(1'b0);
		repeat (8) @(posedge aclk);
		rdc("held", REG_STATUS, 32'h3, 32'h2);
		p = sweep_pos;
		repeat (40) @(negedge aclk);
		chk("paused", 32'(sweep_pos), 32'(p));
		i_src.hold(1'b1);
		repeat (40) @(negedge aclk);
		chk("resumed", 32'(sweep_pos - p - 15'h1 < 15'h7), 32'h1);
		pulse_begin(0);
		chk("restart_pos", 32'(sweep_pos), 32'h0);
		i_src.pulse(1);
		repeat (8) @(posedge aclk);
		rdc("stopped", REG_STATUS, 32'hFFFE3, 32'h0);
		wr(REG_CTRL, 32'h001);
		i_src.pulse(0);
		repeat (10) @(posedge aclk);
		rdc("ext_off", REG_STATUS, 32'h3, 32'h0);
		wr(REG_CTRL, 32'h805);
		pulse_begin(2);
		i_src.hold(1'b0);
		repeat (60) @(posedge aclk);
		rdc("held1", REG_STATUS, 32'h3, 32'h2);
		pulse_begin(0);
		chk("hold_restart", 32'(sweep_pos), 32'h0);
		i_src.hold(1'b1);
		i_src.pulse(1);
		wr(REG_TICK, 32'h1);
		wr(REG_MKPOS, 32'h0);
		wr(REG_CTRL, 32'h002);
		wr(REG_CMD, 32'h01);
		wait_pos(15'h000C);
		chk("mk_clamp", 32'(sync_out), 32'h0);
		wait_pos(15'h0020);
		chk("mk_clamp_hi", 32'(sync_out), 32'h1);
		wr(REG_MKPOS, 32'h100);
		wr(REG_CMD, 32'h01);
		wait_pos(15'h00F0);
		chk("mk_low", 32'(sync_out), 32'h0);
		wait_pos(15'h0110);
		chk("mk_high", 32'(sync_out), 32'h1);
		for (int r = 0; r < 2; r++) begin
			wr(REG_START, r ? 32'h64 : 32'h0);
			wr(REG_STOP, r ? 32'h0 : 32'h64);
			wr(REG_CTRL, 32'h023);
			wr(REG_CMD, 32'h01);
			wait_pos(15'h1000);
			x0 = xdrive_code;
			wait_pos(15'h2000);
			x1 = xdrive_code;
			wait_pos(15'h3000);
			x2 = xdrive_code;
			chk("x_dir", 32'(x1 > x0), r ? 32'h0 : 32'h1);
			chk("x_lin", 32'((x2 - x1) - (x1 - x0) + 12'h2 <= 12'h4), 32'h1);
		end
		wr(REG_CMD, 32'h02);
		wr(REG_CTRL, 32'h005);
		wr(REG_CMD, 32'h40);
		repeat (33000) @(posedge aclk);
		rdc("oneway_end", REG_STATUS, 32'hFFFE3, 32'h0);
		wr(REG_CMD, 32'h40);
		repeat (100) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc("rst_status", REG_STATUS, 32'hFFFFFFEF, 32'h0);
		rdc("rst_ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h0);
		wr(REG_CTRL, 32'h000);
		@(posedge ref_phase);
		repeat (3) @(negedge aclk);
		chk("ref_hi", 32'(sync_out), 32'h1);
		@(negedge ref_phase);
		repeat (3) @(negedge aclk);
		chk("ref_lo", 32'(sync_out), 32'h0);
		print_verdict();
	end
endmodule
`default_nettype wire
